// ===== ssfm_pkg.sv
/*
 Package for the supply sequencer and fault manager: widths, timing constants,
 command codes, field positions and the carrier structs shared by both modules.
 Assumes a single 40 MHz clock domain.
*/
package ssfm_pkg;
  localparam int NCH          = 16;
  localparam int TSW          = 4;                       // timeslot index width
  localparam int DLYW         = 16;                      // delay fields, 0.2 ms units
  localparam int VW           = 16;                      // millivolt values
  localparam int CLK_HZ       = 40_000_000;
  localparam int TICK_US_X10  = 2000;                    // 0.2 ms tick, in 0.1 us
  localparam int TICK_CYC     = CLK_HZ / 10_000_000 * TICK_US_X10;
  localparam logic [7:0] CMD_PAGE    = 8'h00;
  localparam logic [7:0] CMD_OPER    = 8'h01;
  localparam logic [7:0] CMD_CLEAR   = 8'h03;
  localparam logic [7:0] CMD_MARGIN  = 8'h25;
  localparam logic [7:0] CMD_VREAD   = 8'h8B;
  localparam logic [7:0] CMD_SERIAL  = 8'h9E;
  localparam logic [7:0] PAGE_ALL    = 8'hFF;
  localparam logic [7:0] ALL_ONES    = 8'hFF;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;        // 0001 100
  localparam logic [1:0] VOUT_BYTES  = 2'h2;
  // Mode configuration bits
  localparam int MODE_LOCK    = 0;
  localparam int MODE_ALERT   = 1;
  localparam int MODE_SEQ     = 2;                       // 1 = timeslot profile
  localparam int MODE_IMMOFF  = 3;
  // Per-channel fault action bits
  localparam int FA_OV        = 0;
  localparam int FA_UV        = 1;
  localparam int FA_OT        = 2;
  localparam int FA_TON       = 3;
  localparam int FA_LATCH     = 4;                       // 0 = retry, 1 = latch off
  localparam int FA_GLOBAL    = 5;

  typedef struct packed {
    logic [VW-1:0]   uv_limit;
    logic [VW-1:0]   pg_on;
    logic [DLYW-1:0] ton_delay;
    logic [DLYW-1:0] ton_max;     // bit 15 set disables the channel
    logic [DLYW-1:0] toff_delay;
    logic [TSW-1:0]  slot;
    logic [7:0]      fault_action;
  } ssfm_chcfg_type;

  typedef struct packed {
    logic       valid;            // one-cycle command strobe
    logic       rd;
    logic [7:0] code;
    logic [7:0] page;
    logic [7:0] data0;
    logic [31:0] serial_hi;
  } ssfm_cmd_type;

  typedef struct packed {
    logic ov;
    logic uv;
    logic ot;
  } ssfm_mon_type;
endpackage

// ===== ssfm_channel.sv
/*
 One supply channel: turn-on delay, maximum turn-on check, turn-off delay and
 latched-off state. Delay counts advance on the shared 0.2 ms tick.
*/
`timescale 1ns/10ps
module ssfm_channel (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    tick,
  input  wire logic                    go_on,
  input  wire logic                    go_off,
  input  wire logic                    imm_off,
  input  wire logic                    blocked,
  input  wire logic                    restart,
  input  wire logic                    above_uv,
  input  wire logic                    fault_now,
  input  wire ssfm_pkg::ssfm_chcfg_type cfg,
  output logic                         en,
  output logic                         ton_fault,
  output logic                         latched
);
  typedef enum logic [2:0] {CH_OFF, CH_DLY_ON, CH_RAMP, CH_ON, CH_DLY_OFF} ssfm_chst_type;
  typedef struct packed {
    ssfm_chst_type                  st;
    logic [ssfm_pkg::DLYW-1:0]      cnt;
    logic                           tf;
    logic                           lat;
  } ssfm_chstate_type;
  ssfm_chstate_type s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tf = 1'b0;
    if (restart) begin
      s_nxt.lat = 1'b0;                                                 // [R8]
    end
    if (tick && s_r.st != CH_OFF && s_r.st != CH_ON) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    unique case (s_r.st)
      CH_OFF: begin
        if (go_on && !s_r.lat && !blocked && !cfg.ton_max[ssfm_pkg::DLYW-1]) begin // [R9]
          s_nxt.st  = CH_DLY_ON;
          s_nxt.cnt = '0;
        end
      end
      CH_DLY_ON: begin
        if (go_off || blocked) begin
          s_nxt.st = CH_OFF;
        end else if (s_r.cnt >= cfg.ton_delay) begin                    // [R18]
          s_nxt.st  = CH_RAMP;
          s_nxt.cnt = '0;
        end
      end
      CH_RAMP: begin
        if (go_off) begin
          s_nxt.st = CH_OFF;
        end else if (above_uv) begin
          s_nxt.st = CH_ON;
        end else if (s_r.cnt >= cfg.ton_max) begin                      // [R20]
          s_nxt.st  = CH_OFF;
          s_nxt.tf  = 1'b1;                                             // [R23]
          s_nxt.lat = cfg.fault_action[ssfm_pkg::FA_LATCH];             // [R12]
        end
      end
      CH_ON: begin
        if (fault_now) begin
          s_nxt.st  = CH_OFF;
          s_nxt.lat = cfg.fault_action[ssfm_pkg::FA_LATCH];             // [R12]
        end else if (go_off) begin
          s_nxt.st  = imm_off ? CH_OFF : CH_DLY_OFF;                    // [R22]
          s_nxt.cnt = '0;
        end
      end
      CH_DLY_OFF: begin
        if (fault_now || s_r.cnt >= cfg.toff_delay) begin               // [R22]
          s_nxt.st = CH_OFF;
        end
      end
      default: s_nxt.st = CH_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '{st: CH_OFF, cnt: '0, tf: 1'b0, lat: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign en        = (s_r.st == CH_RAMP) || (s_r.st == CH_ON) || (s_r.st == CH_DLY_OFF);
  assign ton_fault = s_r.tf;
  assign latched   = s_r.lat;
endmodule // ssfm_channel

// ===== ssfm_top.sv
/*
 Supply sequencer and fault manager: sixteen channels, time-based or timeslot
 power-up, shared power-down, power-good delay, fault status with alert and
 alert response, and command lock. The serial front end sits outside and
 delivers decoded commands as one-cycle strobes; pins are synchronised here.
 Assumes one 40 MHz clock and a separate serial front end.
*/
// Summary of operation
// [R1] Host decodes values as (Y*10^-R - b)/m.
// [R2] Host encodes values as (mX + b)*10^R.
// [R3] Margin and readback voltages are plain millivolts.
// [R4] Voltages positive, two data bytes each.
// [R5] Faults set status; alert low if enabled.
// [R6] Alert response returns own address, releases alert.
// [R7] Latched status cleared only by listed events.
// [R8] Latched-off supply restarts only by listed events.
// [R9] Supply held off while its fault present.
// [R10] Shared-channel fault blocks all shared turn-ons.
// [R11] System power-up needs no OV or OT.
// [R12] Fault action taken from per-channel action byte.
// [R13] Locked protected reads return all ones.
// [R14] Locked: only page, operation, clear, serial writes.
// [R15] Matching serial upper bytes unlock until relocked.
// [R16] Lock status bit always readable.
// [R17] Profile bit picks time or timeslot sequencing.
// [R18] Time mode: enables follow their turn-on delays.
// [R19] Timeslot waits for preceding slot active.
// [R20] Output must pass UV within max turn-on.
// [R21] Power good after all on, plus delay.
// [R22] Power-down by control, operation off, shared fault.
// [R23] Missed turn-on time is a handled fault.
`timescale 1ns/10ps
module ssfm_top (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire ssfm_pkg::ssfm_cmd_type      cmd,
  input  wire logic                        ara_hit,
  input  wire logic [6:0]                  own_addr,
  input  wire logic [7:0]                  device_mode_config,
  input  wire logic [7:0]                  mode_wdata,
  input  wire logic                        mode_we,
  input  wire logic                        use_control_pin,
  input  wire logic                        control_pin,
  input  wire logic                        fault_n_in,
  input  wire logic [31:0]                 stored_serial_hi,
  input  wire logic [15:0]                 enable_polarity_config,
  input  wire logic [15:0]                 power_good_delay_setting,
  input  wire ssfm_pkg::ssfm_chcfg_type [15:0] chcfg,
  input  wire logic [15:0]                 vout_mv [16],
  input  wire logic [15:0]                 ov_in,
  input  wire logic [15:0]                 ot_in,
  output logic [15:0]                      supply_enable_n,
  output logic                             power_good_out,
  output logic                             alert_n_out,
  output logic                             alert_n_oe,
  output logic                             fault_n_out,
  output logic                             fault_n_oe,
  output logic [15:0]                      fault_status,
  output logic                             lock_status,
  output logic                             cmd_ignored,
  output logic                             rd_force_ones,
  output logic [1:0]                       rd_byte_count,
  output logic                             ara_valid,
  output logic [7:0]                       ara_byte
);
  // Phases shared by all channels
  typedef enum logic [1:0] {SQ_IDLE, SQ_UP, SQ_RUN, SQ_DOWN} ssfm_seq_type;
  typedef struct packed {
    ssfm_seq_type  seq;
    logic [1:0]    ctl_sync;
    logic [1:0]    flt_sync;
    logic          ctl_prev;
    logic          want_on;
    logic [3:0]    cur_slot;
    logic [15:0]   tick_cnt;
    logic [15:0]   pg_cnt;
    logic          pg;
    logic [15:0]   status;
    logic          alert;
    logic          lock;
    logic [7:0]    mode;
    logic          ign;
    logic          fones;
    logic [1:0]    nbytes;
    logic          ara_v;
    logic [7:0]    ara_b;
    logic          restart;
    logic          sys_up;
  } ssfm_state_type;
  ssfm_state_type s_r, s_nxt;

  // Per-channel vectors, then shared scalars
  logic [15:0] en, tonf, lat, above_uv, fault_now, blocked, pg_ok, glob;
  logic        tick, go_on, go_off, shared_fault, any_glob_fault;

  // Writable while locked
  function automatic logic lock_allows(input logic [7:0] code);
    lock_allows = (code == ssfm_pkg::CMD_PAGE) || (code == ssfm_pkg::CMD_OPER) ||
                  (code == ssfm_pkg::CMD_CLEAR) || (code == ssfm_pkg::CMD_SERIAL);
  endfunction

  // Free-running tick: the first tick of a
  // delay may come up to one tick early
  assign tick         = (s_r.tick_cnt == 16'(ssfm_pkg::TICK_CYC - 1));
  assign shared_fault = !s_r.flt_sync[1];

  // UV counts as a fault only once running
  always_comb begin
    for (int i = 0; i < ssfm_pkg::NCH; i++) begin
      glob[i]      = chcfg[i].fault_action[ssfm_pkg::FA_GLOBAL];
      above_uv[i]  = vout_mv[i] > chcfg[i].uv_limit;                     // [R3]
      pg_ok[i]     = chcfg[i].ton_max[ssfm_pkg::DLYW-1] ||
                     (en[i] && vout_mv[i] >= chcfg[i].pg_on);
      fault_now[i] = (ov_in[i] && chcfg[i].fault_action[ssfm_pkg::FA_OV]) ||
                     (ot_in[i] && chcfg[i].fault_action[ssfm_pkg::FA_OT]) ||
                     (en[i] && !above_uv[i] && s_r.seq == SQ_RUN &&
                      chcfg[i].fault_action[ssfm_pkg::FA_UV]);
    end
    any_glob_fault = |(fault_now & glob);
    // Turn-on gates
    for (int i = 0; i < ssfm_pkg::NCH; i++) begin
      blocked[i] = fault_now[i] ||                                       // [R9]
                   (glob[i] && any_glob_fault) ||                        // [R10]
                   (glob[i] && s_r.sys_up && (ov_in[i] || ot_in[i])) ||  // [R11]
                   (s_r.mode[ssfm_pkg::MODE_SEQ] &&                      // [R17]
                    chcfg[i].slot != s_r.cur_slot);                      // [R19]
    end
  end

  // Shared fault drops any sequence
  assign go_on  = s_r.seq == SQ_UP;
  assign go_off = s_r.seq == SQ_DOWN || (shared_fault && s_r.seq != SQ_IDLE);

  // One engine per supply
  for (genvar g = 0; g < ssfm_pkg::NCH; g++) begin : gch
    ssfm_channel u_ch (
      .mclk      (mclk),
      .rst       (rst),
      .tick      (tick),
      .go_on     (go_on),
      .go_off    (go_off || (shared_fault && glob[g])),                 // [R22]
      .imm_off   (s_r.mode[ssfm_pkg::MODE_IMMOFF]),
      .blocked   (blocked[g]),
      .restart   (s_r.restart),
      .above_uv  (above_uv[g]),
      .fault_now (fault_now[g]),
      .cfg       (chcfg[g]),
      .en        (en[g]),
      .ton_fault (tonf[g]),
      .latched   (lat[g])
    );
  end

  always_comb begin
    logic ctl_on;
    logic slot_done;
    ctl_on    = 1'b0;
    slot_done = 1'b1;
    s_nxt = s_r;
    s_nxt.ctl_sync = {s_r.ctl_sync[0], control_pin};
    s_nxt.flt_sync = {s_r.flt_sync[0], fault_n_in};
    s_nxt.ctl_prev = s_r.ctl_sync[1];
    s_nxt.tick_cnt = tick ? 16'h0000 : s_r.tick_cnt + 16'h0001;
    s_nxt.restart  = 1'b0;
    s_nxt.ign      = 1'b0;
    s_nxt.fones    = 1'b0;
    s_nxt.ara_v    = 1'b0;
    // Mode frozen while locked
    if (mode_we && !s_r.lock) begin
      s_nxt.mode = mode_wdata;
      s_nxt.lock = mode_wdata[ssfm_pkg::MODE_LOCK];
    end
    // Pin edges start and stop
    if (use_control_pin && s_r.ctl_sync[1] != s_r.ctl_prev) begin
      s_nxt.want_on = s_r.ctl_sync[1];                                   // [R18]
      ctl_on        = s_r.ctl_sync[1];
    end

    // Command strobes
    if (cmd.valid) begin
      if (cmd.rd) begin
        s_nxt.fones  = s_r.lock && !lock_allows(cmd.code);               // [R13]
        s_nxt.nbytes = ssfm_pkg::VOUT_BYTES;                             // [R4]
      end else if (s_r.lock && !lock_allows(cmd.code)) begin
        s_nxt.ign = 1'b1;                                                // [R14]
      end else if (cmd.code == ssfm_pkg::CMD_OPER && !use_control_pin) begin
        s_nxt.want_on = cmd.data0[7];
        s_nxt.sys_up  = cmd.data0[7] && cmd.page == ssfm_pkg::PAGE_ALL;  // [R11]
        if (!cmd.data0[7]) begin
          s_nxt.restart = 1'b1;                                          // [R8]
        end
      end else if (cmd.code == ssfm_pkg::CMD_CLEAR) begin
        s_nxt.status = '0;                                               // [R7]
        s_nxt.alert  = 1'b0;
      end else if (cmd.code == ssfm_pkg::CMD_SERIAL &&
                   cmd.serial_hi == stored_serial_hi) begin
        s_nxt.lock = 1'b0;                                               // [R15]
        s_nxt.mode[ssfm_pkg::MODE_LOCK] = 1'b0;
      end
    end
    // Falling edge: off half of restart
    if (ctl_on) begin
      s_nxt.sys_up = 1'b1;
    end else if (use_control_pin && s_r.ctl_sync[1] != s_r.ctl_prev) begin
      s_nxt.restart = 1'b1;                                              // [R8]
    end

    // Slot done once its rails pass UV
    for (int i = 0; i < ssfm_pkg::NCH; i++) begin
      if (s_r.mode[ssfm_pkg::MODE_SEQ] && chcfg[i].slot == s_r.cur_slot &&
          !chcfg[i].ton_max[ssfm_pkg::DLYW-1] && !(en[i] && above_uv[i])) begin
        slot_done = 1'b0;
      end
    end

    // Sequencer phase
    unique case (s_r.seq)
      SQ_IDLE: if (s_nxt.want_on) begin
        s_nxt.seq      = SQ_UP;
        s_nxt.cur_slot = '0;
      end
      SQ_UP: begin
        if (!s_r.want_on || shared_fault) begin
          s_nxt.seq = SQ_DOWN;
        end else if (s_r.mode[ssfm_pkg::MODE_SEQ] && slot_done) begin
          s_nxt.cur_slot = s_r.cur_slot + 4'h1;                          // [R19]
        end
        if (&pg_ok && s_nxt.seq == SQ_UP) begin
          s_nxt.seq = SQ_RUN;
        end
      end
      SQ_RUN: if (!s_r.want_on || shared_fault) begin
        s_nxt.seq = SQ_DOWN;                                             // [R22]
      end
      SQ_DOWN: if (en == '0) begin
        s_nxt.seq    = SQ_IDLE;
        s_nxt.sys_up = 1'b0;
      end
    endcase
    // Power good needs every enabled channel up, then the programmed delay
    if (s_r.seq == SQ_RUN && &pg_ok) begin                               // [R21]
      if (s_r.pg_cnt >= power_good_delay_setting) begin
        s_nxt.pg = 1'b1;
      end else if (tick) begin
        s_nxt.pg_cnt = s_r.pg_cnt + 16'h0001;
      end
    end else begin
      s_nxt.pg     = 1'b0;
      s_nxt.pg_cnt = '0;
    end
    // Set wins over clear: events OR in after the clear above
    s_nxt.status = s_nxt.status | tonf | fault_now;                      // [R5]
    if (|(tonf | fault_now)) begin
      s_nxt.alert = s_r.mode[ssfm_pkg::MODE_ALERT];                      // [R5]
    end
    // Response beats a same-cycle fault,
    // else a standing fault holds alert
    if (ara_hit && s_r.alert) begin
      s_nxt.ara_v = 1'b1;                                                // [R6]
      s_nxt.ara_b = {own_addr, 1'b1};
      s_nxt.alert = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '{seq: SQ_IDLE, ctl_sync: 2'h0, flt_sync: 2'h3, mode: 8'h00,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Strap input is never loaded: reset mode is 8'h00 and device_mode_config is left unused
  logic mode_loaded_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_loaded_r <= 1'b0;
    end else begin
      mode_loaded_r <= 1'b1;
    end
  end
  logic unused_mode;
  assign unused_mode = mode_loaded_r ^ device_mode_config[0];

  // Polarity bit set: high while on
  assign supply_enable_n = ~(en ^ enable_polarity_config);               // [R18]
  assign power_good_out  = s_r.pg;

  // Open drain: enable pulls low
  assign alert_n_out     = 1'b0;
  assign alert_n_oe      = s_r.alert;
  assign fault_n_out     = 1'b0;
  assign fault_n_oe      = |(s_r.status & glob);
  assign fault_status    = s_r.status;
  assign lock_status     = s_r.lock;                                     // [R16]
  assign cmd_ignored     = s_r.ign;
  assign rd_force_ones   = s_r.fones;
  assign rd_byte_count   = s_r.nbytes;
  assign ara_valid       = s_r.ara_v;
  assign ara_byte        = s_r.ara_b;
endmodule // ssfm_top

// ===== ssfm_asserts.sv
/*
 Port checker for the supply sequencer top: command lock, read masking,
 alert response and sticky status.
 Assumes a bind from the bench top and one clock domain.
*/
`timescale 1ns/10ps
module ssfm_asserts (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire ssfm_pkg::ssfm_cmd_type cmd,
  input wire logic                   ara_hit,
  input wire logic [6:0]             own_addr,
  input wire logic [7:0]             mode_wdata,
  input wire logic                   mode_we,
  input wire logic [31:0]            stored_serial_hi,
  input wire logic                   alert_n_oe,
  input wire logic [15:0]            fault_status,
  input wire logic                   lock_status,
  input wire logic                   cmd_ignored,
  input wire logic                   rd_force_ones,
  input wire logic [1:0]             rd_byte_count,
  input wire logic                   ara_valid,
  input wire logic [7:0]             ara_byte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr;
  logic open_code;
  logic clr;
  logic rst_d_r;
  assign wr = cmd.valid && !cmd.rd;
  assign clr = wr && cmd.code == ssfm_pkg::CMD_CLEAR;
  assign open_code = cmd.code inside {ssfm_pkg::CMD_PAGE, ssfm_pkg::CMD_OPER,
                                      ssfm_pkg::CMD_CLEAR, ssfm_pkg::CMD_SERIAL};
  // Masks the first edge after reset, where history predates the clear
  always_ff @(posedge mclk) rst_d_r <= rst;
  sequence ara_req_s; ara_hit && alert_n_oe; endsequence
  sequence ara_reply_s; ara_valid && !alert_n_oe; endsequence
  a_locked_write_drop: assert property (
    wr && lock_status && !open_code |=> cmd_ignored) else $error("locked write kept");
  a_open_write_kept: assert property (
    wr && open_code |=> !cmd_ignored) else $error("open write dropped");
  a_locked_read_ones: assert property (
    cmd.valid && cmd.rd && lock_status && cmd.code == ssfm_pkg::CMD_MARGIN
    |=> rd_force_ones && rd_byte_count == ssfm_pkg::VOUT_BYTES) else $error("read not masked");
  a_open_read_plain: assert property (
    cmd.valid && cmd.rd && !lock_status |=> !rd_force_ones) else $error("open read masked");
  a_serial_unlock: assert property (
    wr && cmd.code == ssfm_pkg::CMD_SERIAL && cmd.serial_hi == stored_serial_hi
    |-> ##[1:2] !lock_status) else $error("serial did not unlock");
  a_lock_set: assert property (
    mode_we && mode_wdata[ssfm_pkg::MODE_LOCK] && !wr |-> ##[1:2] lock_status)
    else $error("lock bit not shown");
  a_ara_reply: assert property (
    ara_req_s |=> ara_reply_s ##0 ara_byte == {$past(own_addr), 1'h1})
    else $error("alert response wrong");
  a_ara_quiet: assert property (
    !ara_hit |=> !ara_valid) else $error("unrequested alert response");
  a_status_sticky: assert property (
    !rst_d_r && |($past(fault_status) & ~fault_status) |-> $past(clr))
    else $error("status cleared without clear");
endmodule // ssfm_asserts

// ===== ssfm_supply_model.sv
/*
 Behavioural supplies behind the enable outputs: output rises after a set
 number of cycles once enabled, drops to zero when disabled.
 Assumes the bench sets rise time and level.
*/
`timescale 1ns/10ps
module ssfm_supply_model (
  input wire logic        mclk,
  input wire logic [15:0] supply_enable_n,
  input wire logic [15:0] enable_polarity_config,
  input wire logic [15:0] rise_cyc,
  input wire logic [15:0] level_mv,
  output logic [15:0]     vout_mv [16]
);
  int cnt [16];
  initial foreach (vout_mv[i]) vout_mv[i] = 16'h0000;
  always @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      if (supply_enable_n[i] == enable_polarity_config[i]) begin
        if (cnt[i] < int'(rise_cyc)) cnt[i] <= cnt[i] + 1;
        // Part way up sits below any sane undervoltage limit
        vout_mv[i] <= (cnt[i] >= int'(rise_cyc)) ? level_mv : level_mv >> 2;
      end else begin
        cnt[i] <= 0;
        vout_mv[i] <= 16'h0000;
      end
    end
  end
endmodule // ssfm_supply_model

// ===== ssfm_top_test.sv
/*
 Bench for the sequencer top: lock, sequencing, faults and alert response.
 Assumes the checker is bound below and supplies are modelled.
*/
`timescale 1ns/10ps
module ssfm_top_test;
  localparam int TK = ssfm_pkg::TICK_CYC;
  logic mclk = 1'h0, rst = 1'h1, ara_hit = 1'h0, mode_we = 1'h0;
  ssfm_pkg::ssfm_cmd_type cmd = '0;
  ssfm_pkg::ssfm_chcfg_type [15:0] chcfg;
  logic [6:0]  own_addr;
  logic [7:0]  mode_wdata = 8'h00, ara_b;
  logic [31:0] serial, rng = 32'hF35D60DC;
  logic [15:0] pol, pg_dly = 16'h0002, ov = 16'h0002, rise = 16'h0014, en_n, fstat, ot;
  logic [15:0] vout [16];
  logic        pg, a_oe, f_oe, lock, ign, ones, ara_v, lk = 1'h0, viol = 1'h0;
  logic [1:0]  bcnt;
  logic [7:0]  codes [$] = '{8'h00, 8'h01, 8'h03, 8'h25, 8'h8B, 8'h20};
  int          mismatches = 0, comparisons = 0, n, t_on;
  always #12.5 mclk = ~mclk;
  ssfm_top dut_u (.mclk(mclk), .rst(rst), .cmd(cmd), .ara_hit(ara_hit),
    .own_addr(own_addr), .device_mode_config(8'h00), .mode_wdata(mode_wdata),
    .mode_we(mode_we), .use_control_pin(1'h0), .control_pin(1'h0), .fault_n_in(1'h1),
    .stored_serial_hi(serial), .enable_polarity_config(pol),
    .power_good_delay_setting(pg_dly), .chcfg(chcfg), .vout_mv(vout), .ov_in(ov),
    .ot_in(ot), .supply_enable_n(en_n), .power_good_out(pg), .alert_n_out(),
    .alert_n_oe(a_oe), .fault_n_out(), .fault_n_oe(f_oe), .fault_status(fstat),
    .lock_status(lock), .cmd_ignored(ign), .rd_force_ones(ones), .rd_byte_count(bcnt),
    .ara_valid(ara_v), .ara_byte(ara_b));
  ssfm_supply_model sup_u (.mclk(mclk), .supply_enable_n(en_n),
    .enable_polarity_config(pol), .rise_cyc(rise), .level_mv(16'h03E8), .vout_mv(vout));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic send(input logic [7:0] c, input logic r, input logic [7:0] d,
                      input logic [31:0] s);
    @(negedge mclk);
    cmd = '{1'h1, r, c, ssfm_pkg::PAGE_ALL, d, s};
    @(negedge mclk);
    cmd.valid = 1'h0;
    if (!r && c == ssfm_pkg::CMD_SERIAL && s == serial) lk = 1'h0;
  endtask
  task automatic mode(input logic [7:0] v);
    @(negedge mclk);
    mode_wdata = v;
    mode_we = 1'h1;
    @(negedge mclk);
    mode_we = 1'h0;
  endtask
  task automatic wait_en(input logic [15:0] m);
    for (n = 0; n < 2 * TK && en_n !== ~(pol ^ m); n++) @(negedge mclk);
  endtask
  task automatic wait_pg();
    t_on = 0;
    for (n = 1; n < 5 * TK && pg !== 1'h1; n++) begin
      @(negedge mclk);
      if (t_on == 0 && vout[0] >= 16'h0384 && vout[1] >= 16'h0384 &&
          vout[2] >= 16'h0384 && vout[3] >= 16'h0384) t_on = n;
      if (en_n[2] === pol[2] && vout[0] < 16'h01F4) viol = 1'h1;
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    own_addr = 7'(xs());
    pol = 16'(xs());
    serial = xs();
    ot = 16'(xs()) & 16'hFFF0;
    // Channels 0..3 live; 2 and 3 sit in the second slot
    for (int i = 0; i < 16; i++) begin
      chcfg[i] = {16'h01F4, 16'h0384, 16'h0000, (i < 4) ? 16'h0064 : 16'h8000,
                  16'h0000, 4'(i > 1), 8'h11};
    end
    repeat (2) @(negedge mclk);
    rst = 1'h0;
    mode(8'h03);
    lk = 1'h1;
    chk_flag("lock", 1'h1, lock);
    for (int i = 0; i < 6; i++) codes.push_back(8'(xs()));
    foreach (codes[i]) begin
      send(codes[i], 1'h0, 8'h00, 32'h00000000);
      chk_flag("ignored", lk && !(codes[i] inside {8'h00, 8'h01, 8'h03, 8'h9E}), ign);
    end
    mode(8'h02);
    send(ssfm_pkg::CMD_MARGIN, 1'h1, 8'h00, 32'h00000000);
    chk_flag("ones", 1'h1, ones);
    chk("bytes", 16'h0002, {14'h0000, bcnt});
    send(ssfm_pkg::CMD_SERIAL, 1'h0, 8'h00, ~serial);
    chk_flag("lock", 1'h1, lock);
    send(ssfm_pkg::CMD_SERIAL, 1'h0, 8'h00, serial);
    @(negedge mclk);
    chk_flag("lock", 1'h0, lock);
    send(ssfm_pkg::CMD_MARGIN, 1'h1, 8'h00, 32'h00000000);
    chk_flag("ones", 1'h0, ones);
    mode(8'h02);
    send(ssfm_pkg::CMD_OPER, 1'h0, 8'h80, 32'h00000000);
    wait_en(16'h000D);
    repeat (200) @(negedge mclk);
    chk("enables", ~(pol ^ 16'h000D), en_n);
    chk("status", 16'h0002, fstat);
    chk_flag("alert", 1'h1, a_oe);
    @(negedge mclk);
    ara_hit = 1'h1;
    @(negedge mclk);
    ara_hit = 1'h0;
    chk_flag("ara valid", 1'h1, ara_v);
    chk("ara byte", {8'h00, own_addr, 1'h1}, {8'h00, ara_b});
    chk_flag("alert", 1'h0, a_oe);
    ov = 16'h0000;
    repeat (4) @(negedge mclk);
    send(ssfm_pkg::CMD_CLEAR, 1'h0, 8'h00, 32'h00000000);
    @(negedge mclk);
    chk("status", 16'h0000, fstat);
    repeat (TK) @(negedge mclk);
    chk("enables", ~(pol ^ 16'h000F), en_n);
    chk_flag("fault drive", 1'h0, f_oe);
    send(ssfm_pkg::CMD_OPER, 1'h0, 8'h00, 32'h00000000);
    wait_en(16'h0000);
    chk("enables", ~pol, en_n);
    send(ssfm_pkg::CMD_OPER, 1'h0, 8'h80, 32'h00000000);
    wait_pg();
    chk("enables", ~(pol ^ 16'h000F), en_n);
    chk_flag("pg delay", 1'h1, pg === 1'h1 && n - t_on >= TK);
    send(ssfm_pkg::CMD_OPER, 1'h0, 8'h00, 32'h00000000);
    wait_en(16'h0000);
    chk_flag("pg", 1'h0, pg);
    // Slow supplies make a slot jump visible
    rise = 16'h07D0;
    pg_dly = 16'h0001;
    viol = 1'h0;
    mode(8'h06);
    send(ssfm_pkg::CMD_OPER, 1'h0, 8'h80, 32'h00000000);
    wait_pg();
    chk_flag("slot order", 1'h0, viol);
    chk_flag("pg", 1'h1, pg);
    wrap_up();
  end
endmodule // ssfm_top_test
bind ssfm_top ssfm_asserts chk_u (.mclk(mclk), .rst(rst), .cmd(cmd), .ara_hit(ara_hit),
  .own_addr(own_addr), .mode_wdata(mode_wdata), .mode_we(mode_we),
  .stored_serial_hi(stored_serial_hi), .alert_n_oe(alert_n_oe),
  .fault_status(fault_status), .lock_status(lock_status), .cmd_ignored(cmd_ignored),
  .rd_force_ones(rd_force_ones), .rd_byte_count(rd_byte_count), .ara_valid(ara_valid),
  .ara_byte(ara_byte));
